// >>> design/atd_detector.sv
// Contract
// - detector runs only when embedded-function and tilt enable bits are both set
// - event only after angle stays over threshold for at least the latency
// - after reset only the positive X semi-axis is selected
// - routing bit drives event to pin two; flag always visible in source two
// - unlatched: pin pulse about 75 us, flag held one 26 Hz period
// - latched and routed: reading source two clears pin and flag; re-arm still waits for a tick with the condition gone
// - latched but unrouted: flag still pulses one 26 Hz period
// - latency is 40 ms per step, resets to 0Fh (600 ms)
// - threshold is 15.625 mg per step, full-scale free; host keeps it below 40h
// - threshold angle is arcsine of field over 64; resets to 20h
// - six mask bits pick semi-axes; any selected one over limit counts
// - latency, threshold, mask return to defaults when accelerometer leaves power-down
`include "atd_defines.svh"

module atd_detector #(
  parameter int unsigned TICK_CYCLES = `ATD_TICK_CYCLES,
  parameter int unsigned PULSE_CYCLES = `ATD_PULSE_CYCLES,
  parameter int unsigned SAMPLE_W = 16,
  parameter int unsigned ONE_G_SHIFT = 14
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic signed [SAMPLE_W-1:0] ACCEL_X,
  input wire logic signed [SAMPLE_W-1:0] ACCEL_Y,
  input wire logic signed [SAMPLE_W-1:0] ACCEL_Z,
  output logic IRQ_PIN_TWO
);
  atd_pkg::atd_apb_state_type apb_state_reg;
  atd_pkg::atd_byte_type control_reg_ten_reg;
  atd_pkg::atd_byte_type accel_control_reg_reg;
  atd_pkg::atd_byte_type bank_access_reg_reg;
  atd_pkg::atd_byte_type ths_reg;
  atd_pkg::atd_byte_type lat_reg;
  atd_pkg::atd_byte_type mask_reg;
  logic route_reg;
  logic latch_reg;
  logic tilt_flag_reg;
  logic tilt_flag_next;
  logic fired_reg;
  logic accel_on_reg;
  logic [7:0] persist_cnt_reg;
  logic [7:0] persist_cnt_next;
  logic [31:0] pulse_cnt_reg;
  logic [31:0] pulse_cnt_next;
  logic [31:0] rdata;
  logic hit;

  // one divider paces every evaluation; it idles while the detector is off
  atd_tick_if tick_bus ();

  atd_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk(REF_CLK),
    .rst(RESET),
    .tick_bus(tick_bus.src)
  );

  // bus strobes
  wire logic access = PSEL && PENABLE;
  wire logic commit = access && (apb_state_reg == atd_pkg::ATD_APB_DONE);
  wire logic wr_commit = commit && PWRITE && hit;
  wire logic rd_src_two = commit && !PWRITE && (PADDR == `ATD_ADDR_SRC_TWO);
  wire logic [7:0] wbyte = PWDATA[7:0];
  wire logic bank_open = (bank_access_reg_reg == `ATD_BANK_KEY);

  // shared by the read and both write decoders
  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] target);
    is_addr = (a == target);
  endfunction : is_addr

  // power state and enables
  wire logic accel_on_next = (accel_control_reg_reg[`ATD_RATE_MSB:`ATD_RATE_LSB] != 4'h0);
  wire logic leave_pd = accel_on_next && !accel_on_reg;
  wire logic det_on = control_reg_ten_reg[`ATD_BIT_EMBEDDED_FUNC_ENABLE]
    && control_reg_ten_reg[`ATD_BIT_TILT_EN] && accel_on_reg;
  wire logic tick = tick_bus.tick;
  wire logic latched_routed = latch_reg && route_reg;

  assign tick_bus.run = det_on;

  // threshold scaled to the sample's 1 g weight, so full scale plays no part
  wire logic signed [SAMPLE_W:0] ths_ext =
    (SAMPLE_W+1)'({1'b0, ths_reg}) <<< (ONE_G_SHIFT - `ATD_THS_FRAC_BITS);
  logic signed [SAMPLE_W:0] axis_ext [3];
  logic [5:0] axis_over;
  assign axis_ext[0] = {ACCEL_X[SAMPLE_W-1], ACCEL_X};
  assign axis_ext[1] = {ACCEL_Y[SAMPLE_W-1], ACCEL_Y};
  assign axis_ext[2] = {ACCEL_Z[SAMPLE_W-1], ACCEL_Z};

  // a sample equal to the limit is not over it
  for (genvar g = 0; g < 3; g++) begin : g_axis
    assign axis_over[2*g+1] = axis_ext[g] > ths_ext;
    assign axis_over[2*g] = axis_ext[g] < -ths_ext;
  end

  wire logic cond = |(axis_over & mask_reg[5:0]);

  // persistence in ticks of 1/26 s against latency in 40 ms steps
  wire logic [31:0] held_ms_x = 32'(persist_cnt_next) * 32'(`ATD_MS_PER_S);
  wire logic [31:0] need_ms_x = 32'(lat_reg) * 32'(`ATD_LAT_STEP_MS * `ATD_EVAL_RATE_HZ);
  // cross-multiplied so the 40 ms step needs no divider
  wire logic met = (held_ms_x >= need_ms_x);
  wire logic event_pulse = tick && det_on && cond && met && !fired_reg;

  assign persist_cnt_next = !cond ? 8'h00
    : (persist_cnt_reg == 8'hFF) ? 8'hFF : persist_cnt_reg + 8'h01;

  // set wins over every clear; read clears only a flag the read reported
  always_comb begin
    tilt_flag_next = tilt_flag_reg;
    if (event_pulse) begin
      tilt_flag_next = 1'b1;
    end else if (latched_routed && rd_src_two && PRDATA[`ATD_BIT_FLAG]) begin
      tilt_flag_next = 1'b0;
    end else if (!latched_routed && tick) begin
      tilt_flag_next = 1'b0;
    end else if (!det_on && !latched_routed) begin
      tilt_flag_next = 1'b0;
    end
  end

  // pin pulse is whole clock cycles, so its length rounds up
  assign pulse_cnt_next = (event_pulse && route_reg) ? 32'(PULSE_CYCLES)
    : (pulse_cnt_reg != 32'h00000000) ? pulse_cnt_reg - 32'h00000001 : 32'h00000000;

  // register decode
  always_comb begin
    rdata = 32'h00000000;
    hit = 1'b1;
    if (is_addr(PADDR, `ATD_ADDR_CTRL_TEN)) begin
      rdata = {24'h000000, control_reg_ten_reg};
    end else if (is_addr(PADDR, `ATD_ADDR_PULSE_CFG)) begin
      rdata = {31'h00000000, route_reg};
    end else if (is_addr(PADDR, `ATD_ADDR_LATCH_CFG)) begin
      rdata = {31'h00000000, latch_reg};
    end else if (is_addr(PADDR, `ATD_ADDR_ACCEL_CTRL)) begin
      rdata = {24'h000000, accel_control_reg_reg};
    end else if (is_addr(PADDR, `ATD_ADDR_BANK_ACCESS)) begin
      rdata = {24'h000000, bank_access_reg_reg};
    end else if (is_addr(PADDR, `ATD_ADDR_SRC_TWO)) begin
      rdata = {31'h00000000, tilt_flag_reg};
    end else if (is_addr(PADDR, `ATD_ADDR_THS)) begin
      rdata = {24'h000000, ths_reg};
    end else if (is_addr(PADDR, `ATD_ADDR_LAT)) begin
      rdata = {24'h000000, lat_reg};
    end else if (is_addr(PADDR, `ATD_ADDR_MASK)) begin
      rdata = {24'h000000, mask_reg};
    end else begin
      hit = 1'b0;
    end
  end

  // bus answer: one wait state, pready high on the second access cycle
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      apb_state_reg <= atd_pkg::ATD_APB_IDLE;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else if (access && apb_state_reg == atd_pkg::ATD_APB_IDLE) begin
      apb_state_reg <= atd_pkg::ATD_APB_DONE;
      PREADY <= 1'b1;
      PSLVERR <= !hit;
      PRDATA <= PWRITE ? 32'h00000000 : rdata;
    end else begin
      apb_state_reg <= atd_pkg::ATD_APB_IDLE;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // software registers; source two is read-only
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      control_reg_ten_reg <= `ATD_CTRL_RESET;
      accel_control_reg_reg <= `ATD_CTRL_RESET;
      bank_access_reg_reg <= `ATD_CTRL_RESET;
      route_reg <= 1'b0;
      latch_reg <= 1'b0;
    end else if (wr_commit) begin
      if (is_addr(PADDR, `ATD_ADDR_CTRL_TEN)) begin
        control_reg_ten_reg <= wbyte;
      end else if (is_addr(PADDR, `ATD_ADDR_PULSE_CFG)) begin
        route_reg <= wbyte[`ATD_BIT_ROUTE];
      end else if (is_addr(PADDR, `ATD_ADDR_LATCH_CFG)) begin
        latch_reg <= wbyte[`ATD_BIT_LATCH];
      end else if (is_addr(PADDR, `ATD_ADDR_ACCEL_CTRL)) begin
        accel_control_reg_reg <= wbyte;
      end else if (is_addr(PADDR, `ATD_ADDR_BANK_ACCESS)) begin
        bank_access_reg_reg <= wbyte;
      end
    end
  end

  // bank registers: writable only while the bank key is open
  always_ff @(posedge REF_CLK) begin
    if (RESET || leave_pd) begin
      ths_reg <= `ATD_THS_RESET;
      lat_reg <= `ATD_LAT_RESET;
      mask_reg <= `ATD_MASK_RESET;
    end else if (wr_commit && bank_open) begin
      if (is_addr(PADDR, `ATD_ADDR_THS)) begin
        ths_reg <= wbyte;
      end else if (is_addr(PADDR, `ATD_ADDR_LAT)) begin
        lat_reg <= wbyte;
      end else if (is_addr(PADDR, `ATD_ADDR_MASK)) begin
        mask_reg <= wbyte;
      end
    end
  end

  // detector state
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      accel_on_reg <= 1'b0;
      persist_cnt_reg <= 8'h00;
      fired_reg <= 1'b0;
      tilt_flag_reg <= 1'b0;
      pulse_cnt_reg <= 32'h00000000;
      IRQ_PIN_TWO <= 1'b0;
    end else begin
      accel_on_reg <= accel_on_next;
      tilt_flag_reg <= tilt_flag_next;
      pulse_cnt_reg <= pulse_cnt_next;
      IRQ_PIN_TWO <= route_reg
        && (latched_routed ? tilt_flag_next : (pulse_cnt_next != 32'h00000000));
      if (!det_on) begin
        persist_cnt_reg <= 8'h00;
        fired_reg <= 1'b0;
      end else if (tick) begin
        persist_cnt_reg <= persist_cnt_next;
        // one event per excursion; while enabled, re-armed only when a tick finds the condition gone
        fired_reg <= cond && (fired_reg || event_pulse);
      end
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  a_apb_wait_one: assert property (access && !PREADY |=> PREADY)
    else $error("pready not raised one cycle into access");
  a_disabled_idle: assert property (!det_on |=> persist_cnt_reg == 8'h00 && !fired_reg)
    else $error("persistence kept while detector disabled");
  a_count_restart: assert property (tick && det_on && !cond |=> persist_cnt_reg == 8'h00)
    else $error("persistence not restarted on a quiet tick");
  a_mask_or_count: assert property (tick && det_on && |(axis_over & mask_reg[5:0])
    |=> persist_cnt_reg != 8'h00)
    else $error("selected semi-axis over limit not counted");
  a_event_after_lat: assert property (event_pulse |=> tilt_flag_reg
    && 32'(persist_cnt_reg) * 32'(`ATD_MS_PER_S)
       >= 32'(lat_reg) * 32'(`ATD_LAT_STEP_MS * `ATD_EVAL_RATE_HZ))
    else $error("event raised before latency elapsed");
  a_latch_read_clear: assert property (latched_routed && rd_src_two && !event_pulse
    && PRDATA[`ATD_BIT_FLAG] |=> !tilt_flag_reg && !IRQ_PIN_TWO)
    else $error("latched flag or pin survived source read");
  a_pulse_flag_hold: assert property (!latched_routed && tilt_flag_reg && !tick
    && !rd_src_two && det_on && $stable(latch_reg) && $stable(route_reg) |=> tilt_flag_reg)
    else $error("pulsed flag dropped before next tick");
  a_pin_pulse_start: assert property (event_pulse && route_reg && !latch_reg
    |=> IRQ_PIN_TWO ##1 IRQ_PIN_TWO)
    else $error("pin pulse not started");
  a_unrouted_quiet: assert property (!route_reg |=> !IRQ_PIN_TWO)
    else $error("pin raised while not routed");
  a_bank_defaults: assert property (leave_pd |=> ths_reg == `ATD_THS_RESET
    && lat_reg == `ATD_LAT_RESET && mask_reg == `ATD_MASK_RESET)
    else $error("bank registers not restored on power-up");

  // bus, bank and pin guards
  a_ready_one_pulse: assert property (PREADY |=> !PREADY)
    else $error("pready held past one cycle");
  a_unmapped_error: assert property (access && !PREADY && !hit |=> PSLVERR)
    else $error("unmapped access not flagged");
  a_closed_bank_hold: assert property (wr_commit && !bank_open && !leave_pd
    |=> $stable(ths_reg) && $stable(lat_reg) && $stable(mask_reg))
    else $error("bank register written while bank closed");
  a_bank_write_lands: assert property (wr_commit && bank_open && !leave_pd
    && PADDR == `ATD_ADDR_THS |=> ths_reg == $past(wbyte))
    else $error("threshold write lost with bank open");
  a_mask_write_lands: assert property (wr_commit && bank_open && !leave_pd
    && PADDR == `ATD_ADDR_MASK |=> mask_reg == $past(wbyte))
    else $error("mask write lost with bank open");
  a_tick_clears_flag: assert property (tick && !latched_routed && !event_pulse
    |=> !tilt_flag_reg)
    else $error("pulsed flag outlived its tick");
  a_disabled_flag_clear: assert property (!det_on && !latched_routed |=> !tilt_flag_reg)
    else $error("pulsed flag kept while detector disabled");
  a_latched_pin_hold: assert property (latched_routed && tilt_flag_reg && !rd_src_two
    |=> IRQ_PIN_TWO && tilt_flag_reg)
    else $error("latched flag or pin dropped without a read");
  a_latched_pin_set: assert property (event_pulse && latched_routed |=> IRQ_PIN_TWO)
    else $error("latched event did not raise the pin");

endmodule : atd_detector

// >>> pkg/atd_defines.svh
`ifndef ATD_DEFINES_SVH
`define ATD_DEFINES_SVH

// timing
`define ATD_CLK_HZ 125000000
`define ATD_CLK_PERIOD_NS 8
`define ATD_EVAL_RATE_HZ 26
`define ATD_TICK_CYCLES (`ATD_CLK_HZ / `ATD_EVAL_RATE_HZ)
`define ATD_PULSE_NS 75000
`define ATD_PULSE_CYCLES ((`ATD_PULSE_NS + `ATD_CLK_PERIOD_NS - 1) / `ATD_CLK_PERIOD_NS)
`define ATD_LAT_STEP_MS 40
`define ATD_MS_PER_S 1000

// register byte addresses
`define ATD_ADDR_CTRL_TEN 8'h00
`define ATD_ADDR_PULSE_CFG 8'h04
`define ATD_ADDR_LATCH_CFG 8'h08
`define ATD_ADDR_ACCEL_CTRL 8'h0C
`define ATD_ADDR_BANK_ACCESS 8'h10
`define ATD_ADDR_SRC_TWO 8'h14
`define ATD_ADDR_THS 8'h54
`define ATD_ADDR_LAT 8'h58
`define ATD_ADDR_MASK 8'h5C

// field positions
`define ATD_BIT_EMBEDDED_FUNC_ENABLE 2
`define ATD_BIT_TILT_EN 7
`define ATD_BIT_ROUTE 0
`define ATD_BIT_LATCH 0
`define ATD_BIT_FLAG 0
`define ATD_RATE_MSB 7
`define ATD_RATE_LSB 4

// reset values and keys
`define ATD_CTRL_RESET 8'h00
`define ATD_THS_RESET 8'h20
`define ATD_LAT_RESET 8'h0F
`define ATD_MASK_RESET 8'h02
`define ATD_THS_FRAC_BITS 6
`define ATD_BANK_KEY 8'hA0

`endif

// >>> pkg/atd_pkg.sv
package atd_pkg;

  typedef enum logic {
    ATD_APB_IDLE = 1'b0,
    ATD_APB_DONE = 1'b1
  } atd_apb_state_type;

  typedef logic [7:0] atd_byte_type;

endpackage : atd_pkg

// >>> pkg/atd_tick_if.sv
interface atd_tick_if;
  logic run;
  logic tick;
  modport src (input run, output tick);
  modport sink (output run, input tick);
endinterface : atd_tick_if

// >>> design/atd_tick_gen.sv
`include "atd_defines.svh"

module atd_tick_gen #(
  parameter int unsigned TICK_CYCLES = `ATD_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  atd_tick_if.src tick_bus
);
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic tick_reg;
  wire logic wrap = (count_reg == 32'(TICK_CYCLES - 1));

  // divider restarts while idle so the first evaluation is a full period away
  assign count_next = (!tick_bus.run || wrap) ? 32'h00000000 : count_reg + 32'h00000001;

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= 32'h00000000;
      tick_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg <= tick_bus.run && wrap;
    end
  end

  assign tick_bus.tick = tick_reg;
endmodule : atd_tick_gen

// >>> verification/atd_host.sv
`include "atd_defines.svh"

module atd_host #(
  parameter int TK = 20
) (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // trailing idle edge keeps psel from falling and rising in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rdat, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // only the bench ceiling ends a stuck wait
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task automatic xw(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, {24'h0, d}, r, e);
  endtask : xw
  // caller keeps ths below 40h
  task automatic configure(input logic [7:0] lat, input logic [7:0] ths,
                           input logic [7:0] mask);
    xw(`ATD_ADDR_ACCEL_CTRL, 8'h20);
    xw(`ATD_ADDR_CTRL_TEN, 8'h04);
    repeat (2 * TK) @(posedge clk);
    xw(`ATD_ADDR_CTRL_TEN, 8'h00);
    xw(`ATD_ADDR_BANK_ACCESS, `ATD_BANK_KEY);
    xw(`ATD_ADDR_LAT, lat);
    xw(`ATD_ADDR_THS, ths);
    xw(`ATD_ADDR_MASK, mask);
    xw(`ATD_ADDR_BANK_ACCESS, 8'h00);
    xw(`ATD_ADDR_CTRL_TEN, 8'h84);
  endtask : configure
endmodule : atd_host

// >>> verification/absolute_tilt_detector_test.sv
`include "atd_defines.svh"

module absolute_tilt_detector_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 20;
  localparam int PL = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic signed [15:0] ax = 16'sh0000, ay = 16'sh0000, az = 16'sh0000, ov;
  logic psel, penable, pwrite, pready, pslverr, irq, e;
  logic [7:0] paddr, ths;
  logic [31:0] pwdata, prdata, r;
  int num_errors = 0, num_checks = 0, seed = 32'h0B7C;
  int cyc = 0, hi = 0, rises = 0, plen = 0, el, k;

  always #4 clk = ~clk;

  atd_detector #(.TICK_CYCLES(TK), .PULSE_CYCLES(PL)) DUT (
    .REF_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .ACCEL_X(ax), .ACCEL_Y(ay), .ACCEL_Z(az), .IRQ_PIN_TWO(irq));
  atd_host #(.TK(TK)) host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, r, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, {24'h0, d}, r, e);
  endtask : wr
  // ticks of persistence for a latency code: 40 ms steps over a 26 Hz tick
  function automatic int need(input int lat);
    int n;
    n = (lat * 1040 + 999) / 1000;
    return (n == 0) ? 1 : n;
  endfunction : need
  task automatic wait_rise(input int maxc);
    int r0;
    r0 = rises;
    el = 0;
    while (rises == r0 && el < maxc) begin
      @(posedge clk);
      el++;
    end
  endtask : wait_rise
  task automatic expect_event(input int n);
    wait_rise((n + 2) * TK);
    chk(32'(el > (n - 1) * TK && el <= n * TK + 4), 32'h1);
  endtask : expect_event
  task automatic set_axis(input int b, input logic signed [15:0] m);
    logic signed [15:0] v;
    v = b[0] ? m : -m;
    case (b >> 1)
      0: ax <= v;
      1: ay <= v;
      default: az <= v;
    endcase
  endtask : set_axis

  // pulse-width and edge monitor, plus the run ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    hi <= (irq === 1'b1) ? hi + 1 : 0;
    if (irq === 1'b1 && hi == 0) rises <= rises + 1;
    if (irq !== 1'b1 && hi != 0) plen <= hi;
    if (cyc == 30000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`ATD_ADDR_THS); chk(r, 32'h20);
    rd(`ATD_ADDR_LAT); chk(r, 32'h0F);
    rd(`ATD_ADDR_MASK); chk(r, 32'h02);
    rd(8'h60); chk(32'(e), 32'h1);
    wr(`ATD_ADDR_THS, 8'h05); rd(`ATD_ADDR_THS); chk(r, 32'h20);
    ths = 8'd16 + 8'($unsigned($random(seed)) % 48);
    ov = $signed({ths, 8'h01});
    ay <= 16'($random(seed) % 4096);
    az <= 16'($random(seed) % 4096);
    ax <= $signed({ths, 8'h00});
    host.configure(8'd2, ths, 8'h02);
    wr(`ATD_ADDR_PULSE_CFG, 8'h01);
    wait_rise(5 * TK); chk(32'(rises), 32'h0);
    ax <= ov; expect_event(need(2));
    rd(`ATD_ADDR_SRC_TWO); chk(r, 32'h1);
    repeat (PL + 2) @(posedge clk); chk(32'(plen), 32'(PL));
    ax <= 16'sh0000;
    repeat (TK + 4) @(posedge clk);
    rd(`ATD_ADDR_SRC_TWO); chk(r, 32'h0);
    ax <= ov; repeat (2 * TK) @(posedge clk);
    ax <= 16'sh0000; repeat (2 * TK) @(posedge clk);
    ax <= ov; expect_event(need(2));
    ax <= 16'sh0000; repeat (2 * TK) @(posedge clk);
    wr(`ATD_ADDR_LATCH_CFG, 8'h01);
    ax <= ov; wait_rise(5 * TK);
    ax <= 16'sh0000; repeat (3 * TK) @(posedge clk);
    chk(32'(irq), 32'h1);
    rd(`ATD_ADDR_SRC_TWO); chk(r, 32'h1);
    chk(32'(irq), 32'h0);
    rd(`ATD_ADDR_SRC_TWO); chk(r, 32'h0);
    wr(`ATD_ADDR_PULSE_CFG, 8'h00);
    k = rises;
    ax <= ov;
    el = 0;
    r = 32'h0;
    while (r[0] !== 1'b1 && el < 30) begin
      rd(`ATD_ADDR_SRC_TWO);
      el++;
    end
    chk(r, 32'h1);
    ax <= 16'sh0000; repeat (TK + 2) @(posedge clk);
    rd(`ATD_ADDR_SRC_TWO); chk(r, 32'h0);
    chk(32'(rises), 32'(k));
    wr(`ATD_ADDR_LATCH_CFG, 8'h00); wr(`ATD_ADDR_PULSE_CFG, 8'h01);
    ay <= 16'sh0000; az <= 16'sh0000;
    host.configure(8'd0, ths, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(`ATD_ADDR_BANK_ACCESS, `ATD_BANK_KEY); wr(`ATD_ADDR_MASK, 8'(1 << i));
      wr(`ATD_ADDR_BANK_ACCESS, 8'h00);
      set_axis(i ^ 1, ov); wait_rise(3 * TK); chk(32'(el), 32'(3 * TK));
      set_axis(i, ov); expect_event(need(0));
      set_axis(i, 16'sh0000); repeat (2 * TK) @(posedge clk);
    end
    wr(`ATD_ADDR_CTRL_TEN, 8'h04);
    set_axis(5, ov);
    wait_rise(3 * TK); chk(32'(el), 32'(3 * TK));
    wr(`ATD_ADDR_CTRL_TEN, 8'h80);
    wait_rise(3 * TK); chk(32'(el), 32'(3 * TK));
    wr(`ATD_ADDR_CTRL_TEN, 8'h84); expect_event(1);
    wr(`ATD_ADDR_ACCEL_CTRL, 8'h00); wr(`ATD_ADDR_ACCEL_CTRL, 8'h20);
    rd(`ATD_ADDR_THS); chk(r, 32'h20);
    rd(`ATD_ADDR_LAT); chk(r, 32'h0F);
    rd(`ATD_ADDR_MASK); chk(r, 32'h02);
    summarize();
  end
endmodule : absolute_tilt_detector_test
